// [scp_consts.svh]
// Constants for the serial configuration memory read and program logic.
// Assumes inclusion by the package and by any file needing raw figures.
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// ****************************************
// Array geometry
// ****************************************
`define SCP_WORD_BITS       32
`define SCP_ADDR_W          13
`define SCP_BIT_W           5
`define SCP_LAST_BIT        5'h1F
`define SCP_LAST_ADDR_128K  13'h0FFF
`define SCP_LAST_ADDR_64K   13'h07FF
`define SCP_MEM_WORDS       4097

// ****************************************
// Reset values and timing counts
// ****************************************
`define SCP_POL_RESET       1'b1
`define SCP_PROG_EDGES      2'h2
`define SCP_VCNT_MAX        2'h3

`endif

// [scp_pkg.sv]
// Types shared by the serial configuration memory design files.
// Assumes scp_consts.svh is reachable on the include path.
`include "scp_consts.svh"

package scp_pkg;

  // ****************************************
  // Cascade output states
  // ****************************************
  typedef enum logic [1:0] {CEO_IDLE, CEO_DONE, CEO_FOLLOW} scp_ceo_state_t;

  // ****************************************
  // Grouped signals
  // ****************************************
  typedef struct packed {
    logic select_n;
    logic clear_gate;
    logic vpp_high;
  } scp_pins_t;

  typedef struct packed {
    logic [`SCP_ADDR_W-1:0] addr;
    logic [`SCP_BIT_W-1:0]  bitn;
  } scp_ptr_t;

  typedef struct packed {
    logic bit_out;
    logic done;
    logic prog;
    logic pol_high;
  } scp_link_stat_t;

endpackage : scp_pkg

// [scp_sync.sv]
// Two-stage level synchroniser of parameterised width.
// Assumes each bit is an independent, slowly changing level.
`timescale 1ns/1ps

module scp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb
  begin
    meta_d = d;
    q_d    = meta_q;
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    meta_q <= meta_d;
    q      <= q_d;
  end
endmodule : scp_sync

// [scp_mem.sv]
// Word array of the configuration store plus overflow word.
// Assumes writes and reads come from the serial clock domain.
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_mem (
  input  wire logic                      clk,
  input  wire logic                      wr_en,
  input  wire logic [`SCP_ADDR_W-1:0]    wr_addr,
  input  wire logic [`SCP_WORD_BITS-1:0] wr_data,
  input  wire logic [`SCP_ADDR_W-1:0]    rd_addr,
  output logic      [`SCP_WORD_BITS-1:0] rd_data
);
  logic [`SCP_WORD_BITS-1:0] mem_q [0:`SCP_MEM_WORDS-1];

  always_ff @(posedge clk)
  begin
    if (wr_en && (wr_addr < `SCP_MEM_WORDS))
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Addresses beyond the array read as erased cells
  always_comb
  begin
    if (rd_addr < `SCP_MEM_WORDS)
    begin
      rd_data = mem_q[rd_addr];
    end
    else
    begin
      rd_data = '1;
    end
  end
endmodule : scp_mem

// [scp_reader.sv]
// Read and program logic of a one-time-programmable serial configuration memory.
// Assumes the host drives the serial clock and pin levels in step with that clock;
// CLK is a free-running local clock that owns the data and cascade pin drivers.
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_reader (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic CONFIG_SERIAL_CLOCK,
  input  wire logic CHIP_SELECT_N,
  input  wire logic CLEAR_GATE,
  input  wire logic VPP_HIGH,
  input  wire logic SIZE_64K,
  input  wire logic DATA_I,
  output logic      DATA_O,
  output logic      DATA_OE_N,
  output logic      CASCADE_SELECT_OUT_N,
  output logic      STANDBY,
  output logic      PROG_MODE
);
  import scp_pkg::*;

  // ****************************************
  // Serial clock domain: reset and strap
  // ****************************************
  logic [1:0] lk_strap;
  logic       rst_l;
  logic       size_q;
  logic       size_d;

  scp_sync #(.W(2)) u_sync_link (
    .clk (CONFIG_SERIAL_CLOCK),
    .d   ({RST, SIZE_64K}),
    .q   (lk_strap)
  );

  assign rst_l = lk_strap[1];

  // Strap caught while reset is held on the serial side
  always_comb
  begin
    size_d = size_q;
    if (rst_l)
    begin
      size_d = lk_strap[0];
    end
  end

  always_ff @(posedge CONFIG_SERIAL_CLOCK)
  begin
    size_q <= size_d;
  end

  // ****************************************
  // Serial clock domain: counters and array
  // ****************************************
  scp_pins_t                 pin;
  scp_ptr_t                  ptr_q;
  scp_ptr_t                  ptr_d;
  logic                      prog_q;
  logic                      prog_d;
  logic [1:0]                vcnt_q;
  logic [1:0]                vcnt_d;
  logic                      done_q;
  logic                      done_d;
  logic                      pol_q;
  logic                      pol_d;
  logic [`SCP_WORD_BITS-1:0] shift_q;
  logic [`SCP_WORD_BITS-1:0] shift_d;
  logic                      bit_q;
  logic                      bit_d;
  logic                      wr_en;
  logic [`SCP_WORD_BITS-1:0] wr_word;
  logic [`SCP_WORD_BITS-1:0] rd_word;
  logic [`SCP_ADDR_W-1:0]    last_addr;
  logic                      clear_now;
  logic                      gate_act;
  logic                      reading;
  logic                      at_last;
  logic                      exit_prog;

  assign pin = '{select_n: CHIP_SELECT_N, clear_gate: CLEAR_GATE, vpp_high: VPP_HIGH};

  scp_mem u_mem (
    .clk     (CONFIG_SERIAL_CLOCK),
    .wr_en   (wr_en),
    .wr_addr (ptr_q.addr),
    .wr_data (wr_word),
    .rd_addr (ptr_d.addr),
    .rd_data (rd_word)
  );

  always_comb
  begin
    last_addr = size_q ? `SCP_LAST_ADDR_64K : `SCP_LAST_ADDR_128K;
    // Polarity applies to reads only; programming uses the raw levels
    clear_now = !prog_q && (pol_q ? pin.clear_gate : !pin.clear_gate);
    gate_act  = !prog_q && (pol_q ? !pin.clear_gate : pin.clear_gate);
    reading   = !pin.select_n && gate_act && !done_q;
    at_last   = (ptr_q.addr == last_addr) && (ptr_q.bitn == `SCP_LAST_BIT);
    exit_prog = !pin.select_n && !pin.clear_gate;
    wr_word   = {DATA_I, shift_q[`SCP_WORD_BITS-1:1]};
    ptr_d     = ptr_q;
    prog_d    = prog_q;
    vcnt_d    = vcnt_q;
    done_d    = done_q;
    pol_d     = pol_q;
    shift_d   = shift_q;
    wr_en     = 1'b0;
    if (rst_l)
    begin
      ptr_d  = '0;
      prog_d = 1'b0;
      vcnt_d = 2'h0;
      done_d = 1'b0;
      pol_d  = `SCP_POL_RESET;
    end
    else if (prog_q)
    begin
      if (exit_prog)
      begin
        prog_d = 1'b0;
        ptr_d  = '0;
      end
      else if (pin.select_n && pin.clear_gate)
      begin
        shift_d    = wr_word;
        ptr_d.bitn = ptr_q.bitn + `SCP_BIT_W'(1);
        if (ptr_q.bitn == `SCP_LAST_BIT)
        begin
          wr_en = 1'b1;
          if (ptr_q.addr == last_addr + `SCP_ADDR_W'(1))
          begin
            pol_d = |wr_word;
          end
        end
      end
      else if (pin.select_n)
      begin
        ptr_d.addr = ptr_q.addr + `SCP_ADDR_W'(1);
        ptr_d.bitn = '0;
      end
      else
      begin
        ptr_d.bitn = ptr_q.bitn + `SCP_BIT_W'(1);
      end
    end
    else
    begin
      if (pin.vpp_high)
      begin
        vcnt_d = (vcnt_q == `SCP_VCNT_MAX) ? vcnt_q : vcnt_q + 2'h1;
        if (vcnt_q + 2'h1 >= `SCP_PROG_EDGES)
        begin
          prog_d = 1'b1;
          ptr_d  = '0;
          done_d = 1'b0;
          // Fresh count, so a later entry again needs two high edges
          vcnt_d = 2'h0;
        end
      end
      else
      begin
        vcnt_d = 2'h0;
      end
      if (!prog_d)
      begin
        if (clear_now)
        begin
          ptr_d  = '0;
          done_d = 1'b0;
        end
        else if (reading)
        begin
          if (at_last)
          begin
            done_d = 1'b1;
          end
          else
          begin
            ptr_d = scp_ptr_t'(ptr_q + 1'b1);
          end
        end
      end
    end
    bit_d = rd_word[ptr_d.bitn];
  end

  always_ff @(posedge CONFIG_SERIAL_CLOCK)
  begin
    ptr_q   <= ptr_d;
    prog_q  <= prog_d;
    vcnt_q  <= vcnt_d;
    done_q  <= done_d;
    pol_q   <= pol_d;
    shift_q <= shift_d;
    bit_q   <= bit_d;
  end

  // ****************************************
  // Crossing into the local clock domain
  // ****************************************
  scp_pins_t      pin_s;
  scp_link_stat_t stat_s;
  scp_link_stat_t stat_l;

  assign stat_l = '{bit_out: bit_q, done: done_q, prog: prog_q, pol_high: pol_q};

  scp_sync #(.W(3)) u_sync_pins (
    .clk (CLK),
    .d   (pin),
    .q   (pin_s)
  );

  scp_sync #(.W(4)) u_sync_stat (
    .clk (CLK),
    .d   (stat_l),
    .q   (stat_s)
  );

  // ****************************************
  // Local domain: pin drivers and cascade
  // ****************************************
  scp_ceo_state_t ceo_st_q;
  scp_ceo_state_t ceo_st_d;
  logic           done_prev_q;
  logic           data_q;
  logic           data_d;
  logic           oe_n_q;
  logic           oe_n_d;
  logic           ceo_n_q;
  logic           ceo_n_d;
  logic           standby_q;
  logic           standby_d;
  logic           prog_o_q;
  logic           clear_c;
  logic           gate_c;
  logic           drive;

  always_comb
  begin
    clear_c  = !stat_s.prog && (stat_s.pol_high ? pin_s.clear_gate : !pin_s.clear_gate);
    gate_c   = !stat_s.prog && (stat_s.pol_high ? !pin_s.clear_gate : pin_s.clear_gate);
    // Final bit handed off; the downstream part owns the line
    drive    = !pin_s.select_n && (stat_s.prog ? pin_s.clear_gate : (gate_c && !stat_s.done));
    data_d   = stat_s.bit_out;
    oe_n_d   = !drive;
    ceo_st_d = ceo_st_q;
    case (ceo_st_q)
      CEO_IDLE:
      begin
        if (stat_s.done && !done_prev_q && !stat_s.prog)
        begin
          ceo_st_d = CEO_DONE;
        end
      end
      CEO_DONE:
      begin
        if (clear_c || stat_s.prog)
        begin
          ceo_st_d = CEO_IDLE;
        end
        else if (pin_s.select_n)
        begin
          ceo_st_d = CEO_FOLLOW;
        end
      end
      CEO_FOLLOW:
      begin
        if (clear_c || stat_s.prog)
        begin
          ceo_st_d = CEO_IDLE;
        end
      end
      default:
      begin
        ceo_st_d = CEO_IDLE;
      end
    endcase
    if (stat_s.prog)
    begin
      ceo_n_d = stat_s.pol_high;
    end
    else
    begin
      case (ceo_st_d)
        CEO_DONE:   ceo_n_d = 1'b0;
        CEO_FOLLOW: ceo_n_d = pin_s.select_n;
        default:    ceo_n_d = 1'b1;
      endcase
    end
    standby_d = pin_s.select_n;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ceo_st_q    <= CEO_IDLE;
      done_prev_q <= 1'b0;
      data_q      <= 1'b0;
      oe_n_q      <= 1'b1;
      ceo_n_q     <= 1'b1;
      standby_q   <= 1'b1;
      prog_o_q    <= 1'b0;
    end
    else
    begin
      ceo_st_q    <= ceo_st_d;
      done_prev_q <= stat_s.done;
      data_q      <= data_d;
      oe_n_q      <= oe_n_d;
      ceo_n_q     <= ceo_n_d;
      standby_q   <= standby_d;
      prog_o_q    <= stat_s.prog;
    end
  end

  assign DATA_O               = data_q;
  assign DATA_OE_N            = oe_n_q;
  assign CASCADE_SELECT_OUT_N = ceo_n_q;
  assign STANDBY              = standby_q;
  assign PROG_MODE            = prog_o_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_vpp_two;
    (pin.vpp_high && !prog_q)[*2];
  endsequence

  sequence s_sel_gate_low;
    !pin_s.select_n && gate_c && !stat_s.done && !stat_s.prog;
  endsequence

  standby_hiz_a: assert property (@(posedge CLK) disable iff (RST)
    pin_s.select_n |=> DATA_OE_N) else $error("data driven in standby");
  drive_gate_a: assert property (@(posedge CLK) disable iff (RST)
    !DATA_OE_N |-> $past(!pin_s.select_n)) else $error("data driven while deselected");
  drive_on_a: assert property (@(posedge CLK) disable iff (RST)
    s_sel_gate_low |=> !DATA_OE_N) else $error("data not driven when selected");
  clear_count_a: assert property (@(posedge CONFIG_SERIAL_CLOCK) disable iff (rst_l)
    clear_now |=> (ptr_q == '0) && !done_q) else $error("clear did not zero counters");
  hold_count_a: assert property (@(posedge CONFIG_SERIAL_CLOCK) disable iff (rst_l)
    (pin.select_n && !prog_q && !clear_now && !pin.vpp_high) |=> $stable(ptr_q)) else $error("counter moved");
  advance_bit_a: assert property (@(posedge CONFIG_SERIAL_CLOCK) disable iff (rst_l)
    (reading && !at_last && !pin.vpp_high) |=> (ptr_q == scp_ptr_t'($past(ptr_q) + 1'b1)))
    else $error("bit pointer did not advance");
  last_done_a: assert property (@(posedge CONFIG_SERIAL_CLOCK) disable iff (rst_l)
    (reading && at_last && !pin.vpp_high) |=> done_q && $stable(ptr_q)) else $error("no hand-off after last bit");
  ceo_low_a: assert property (@(posedge CLK) disable iff (RST)
    (ceo_st_q == CEO_DONE) |-> !CASCADE_SELECT_OUT_N ##0 DATA_OE_N) else $error("cascade hand-off wrong");
  ceo_follow_a: assert property (@(posedge CLK) disable iff (RST)
    (ceo_st_q == CEO_FOLLOW && !stat_s.prog) |-> CASCADE_SELECT_OUT_N == $past(pin_s.select_n))
    else $error("cascade output not following select");
  prog_entry_a: assert property (@(posedge CONFIG_SERIAL_CLOCK) disable iff (rst_l)
    s_vpp_two |=> prog_q) else $error("programming mode not entered");
  prog_hold_a: assert property (@(posedge CONFIG_SERIAL_CLOCK) disable iff (rst_l)
    (!prog_q && !(pin.vpp_high && $past(pin.vpp_high))) |=> !prog_q)
    else $error("programming mode entered early");
  pol_show_a: assert property (@(posedge CLK) disable iff (RST)
    (stat_s.prog && $past(stat_s.prog)) |-> CASCADE_SELECT_OUT_N == $past(stat_s.pol_high))
    else $error("polarity not shown on cascade output");
  pol_store_a: assert property (@(posedge CONFIG_SERIAL_CLOCK) disable iff (rst_l)
    (wr_en && ptr_q.addr == last_addr + `SCP_ADDR_W'(1)) |=> pol_q == $past(|wr_word))
    else $error("polarity word not captured");
  prog_addr_a: assert property (@(posedge CONFIG_SERIAL_CLOCK) disable iff (rst_l)
    (prog_q && pin.select_n && !pin.clear_gate) |=> ptr_q.addr == $past(ptr_q.addr) + `SCP_ADDR_W'(1))
    else $error("programming address did not step");

endmodule : scp_reader

// [scp_host_model.sv]
// Behavioural host configuration port facing the serial configuration memory.
// Assumes the bench calls step once for each serial clock period it wants.
`timescale 1ns/1ps

module scp_host_model (
  output logic             sclk,
  output scp_pkg::scp_pins_t pins,
  output logic             din,
  input  wire logic        data_o,
  input  wire logic        data_oe_n,
  output logic             seen
);
  import scp_pkg::*;

  logic last_q;
  logic line;

  // ****************************************
  // Shared data line
  // ****************************************
  // Released line shows the inverse of its last level, never a stale copy
  assign line = data_oe_n ? ~last_q : data_o;

  always @(data_o or data_oe_n)
    if (!data_oe_n)
      last_q = data_o;

  initial
  begin
    sclk = 1'b0;
    pins = '{select_n: 1'b1, clear_gate: 1'b1, vpp_high: 1'b0};
    din = 1'b0;
    seen = 1'b0;
    last_q = 1'b0;
  end

  // ****************************************
  // One serial clock period
  // ****************************************
  // Pins move in the low phase; the clock stops low between calls
  task automatic step(input logic sel_n, input logic gate, input logic vpp, input logic d);
  begin
    pins.select_n = sel_n;
    pins.clear_gate = gate;
    pins.vpp_high = vpp;
    din = d;
    #62.5;
    sclk = 1'b1;
    seen = line;
    #62.5;
    sclk = 1'b0;
  end
  endtask : step

endmodule : scp_host_model

// [scp_tb.sv]
// Self-checking bench for the serial configuration memory read logic.
// Assumes the host model drives the serial side; expectations queue to a monitor.
`timescale 1ns/1ps

module testbench;
  import scp_pkg::*;

  logic        clk;
  logic        rst;
  logic        data_o;
  logic        data_oe_n;
  logic        cso_n;
  logic        standby;
  logic        prog_mode;
  logic        sclk;
  logic        din;
  logic        seen;
  logic        size64;
  scp_pins_t   pins;
  logic [9:0]  notes[$];
  logic [9:0]  n;
  logic [63:0] wd;
  integer      seed;
  int          i;
  int          miscompares;
  int          checks;
  event        look;

  scp_reader dut (
    .CLK                 (clk),
    .RST                 (rst),
    .CONFIG_SERIAL_CLOCK (sclk),
    .CHIP_SELECT_N       (pins.select_n),
    .CLEAR_GATE          (pins.clear_gate),
    .VPP_HIGH            (pins.vpp_high),
    .SIZE_64K            (size64),
    .DATA_I              (din),
    .DATA_O              (data_o),
    .DATA_OE_N           (data_oe_n),
    .CASCADE_SELECT_OUT_N(cso_n),
    .STANDBY             (standby),
    .PROG_MODE           (prog_mode)
  );

  scp_host_model host (
    .sclk     (sclk),
    .pins     (pins),
    .din      (din),
    .data_o   (data_o),
    .data_oe_n(data_oe_n),
    .seen     (seen)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Checking
  // ****************************************
  task automatic chk(input logic [4:0] seen_v, input logic [4:0] exp_v);
  begin
    checks++;
    if (seen_v !== exp_v)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  end
  endtask : chk

  // Mask and value over {oe_n, cascade_n, standby, prog, sampled data}
  task automatic note(input logic [4:0] m, input logic [4:0] v);
  begin
    notes.push_back({m, v});
    ->look;
  end
  endtask : note

  initial
  begin
    forever
    begin
      @(look);
      while (notes.size() > 0)
      begin
        n = notes.pop_front();
        chk({data_oe_n, cso_n, standby, prog_mode, seen} & n[9:5], n[4:0]);
      end
    end
  end

  task automatic results;
  begin
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask : results

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 32'h6a8d1ecb;
    miscompares = 0;
    checks = 0;
    rst = 1'b1;
    size64 = 1'b1;
    wd = {$random(seed), $random(seed)};
    repeat (5) @(posedge clk);
    // Serial side needs its own edges to see the reset
    repeat (3) host.step(1'b1, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) host.step(1'b1, 1'b1, 1'b0, 1'b0);
    note(5'h1E, 5'h1C);
    repeat (2) host.step(1'b1, 1'b0, 1'b1, 1'b0);
    note(5'h1E, 5'h1E);
    for (i = 0; i < 64; i++)
    begin
      if (i == 32)
        host.step(1'b1, 1'b0, 1'b1, 1'b0);
      host.step(1'b1, 1'b1, 1'b1, wd[i]);
    end
    host.step(1'b0, 1'b0, 1'b0, 1'b0);
    note(5'h1E, 5'h08);
    host.step(1'b0, 1'b1, 1'b0, 1'b0);
    note(5'h1E, 5'h18);
    for (i = 0; i < 40; i++)
    begin
      if (i == 20)
      begin
        host.step(1'b1, 1'b0, 1'b0, 1'b0);
        note(5'h1E, 5'h1C);
      end
      host.step(1'b0, 1'b0, 1'b0, 1'b0);
      note(5'h11, {4'h0, wd[i]});
    end
    host.step(1'b0, 1'b1, 1'b0, 1'b0);
    note(5'h10, 5'h10);
    host.step(1'b0, 1'b0, 1'b0, 1'b0);
    note(5'h11, {4'h0, wd[0]});
    // Step to the overflow word of the smaller part and store all zeros
    repeat (2) host.step(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (2048) host.step(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (32) host.step(1'b1, 1'b1, 1'b1, 1'b0);
    host.step(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (2) host.step(1'b1, 1'b0, 1'b1, 1'b0);
    note(5'h1E, 5'h16);
    for (i = 0; i < 2; i++)
    begin
      host.step(1'b0, 1'b1, 1'b1, 1'b0);
      note(5'h11, {4'h0, wd[i]});
    end
    host.step(1'b0, 1'b0, 1'b0, 1'b0);
    note(5'h1E, 5'h18);
    for (i = 0; i < 4; i++)
    begin
      host.step(1'b0, 1'b1, 1'b0, 1'b0);
      note(5'h11, {4'h0, wd[i]});
    end
    host.step(1'b1, 1'b1, 1'b0, 1'b0);
    note(5'h1E, 5'h1C);
    // Second reset as the larger part: polarity back to its default,
    // and a zero word one past the smaller part's end is plain data
    @(posedge clk);
    #1;
    rst = 1'b1;
    size64 = 1'b0;
    repeat (3) host.step(1'b1, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) host.step(1'b1, 1'b1, 1'b0, 1'b0);
    note(5'h1E, 5'h1C);
    repeat (2) host.step(1'b1, 1'b0, 1'b1, 1'b0);
    note(5'h1E, 5'h1E);
    repeat (2048) host.step(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (32) host.step(1'b1, 1'b1, 1'b1, 1'b0);
    note(5'h1E, 5'h1E);
    #20;
    results();
  end

  // Whole run is about 4300 serial periods
  initial
  begin
    #700000;
    miscompares++;
    results();
  end

endmodule : testbench
